//--- rtl/scsp_top.sv
// Clock control register file, source selection and prescaler for the system clock.
// Assumes oscillator outputs arrive asynchronously and are far slower than clock_i.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module scsp_top #(
  parameter logic [6:0] TRIM_INIT = scsp_pkg::TRIM_RESET
) (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  input  wire logic       idle_mode_i,
  input  wire logic       fast_osc_i,
  input  wire logic       slow_osc_i,
  output logic            sys_tick_o,
  output logic            periph_tick_o,
  output logic            fast_osc_run_o,
  output logic            fast_crystal_o,
  output logic            slow_crystal_o,
  output logic            xtal_pins_o,
  output logic            xtal_high_gain_o,
  output logic [6:0]      fast_rc_trim_value_o,
  output logic            active_fast_o
);
  scsp_pkg::scsp_bus_s  bus;
  scsp_pkg::scsp_ctrl_s ctrl_q;
  scsp_pkg::scsp_ctrl_s ctrl_d;
  logic [6:0] trim_q;
  logic [2:0] fast_sync_q;
  logic [2:0] slow_sync_q;
  logic       fast_lvl_q;
  logic       slow_lvl_q;
  logic       fast_edge;
  logic       slow_edge;
  logic       src_edge;
  logic       sel_fast_q;
  logic       tick;
  logic       hit_ctrl;
  logic       hit_trim;
  logic       wr_ctrl;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_mux;

  assign bus      = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign hit_ctrl = (bus.addr == scsp_pkg::CLOCK_SOURCE_CONTROL_ADDR);
  assign hit_trim = (bus.addr == scsp_pkg::FAST_RC_TRIM_ADDR);
  assign wr_ctrl  = bus.wr && hit_ctrl;

  // Each protected field keeps its old value when the mode forbids the change.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      if (ctrl_q.sysclk_use_fast) begin
        ctrl_d.slow_source_kind = bus.wdata[scsp_pkg::SLOW_KIND_BIT];
      end
      if (!ctrl_q.sysclk_use_fast) begin
        ctrl_d.fast_source_kind = bus.wdata[scsp_pkg::FAST_KIND_BIT];
        ctrl_d.fast_osc_halt    = bus.wdata[scsp_pkg::HALT_BIT];
      end
      if (!ctrl_q.fast_osc_halt) begin
        ctrl_d.sysclk_use_fast = bus.wdata[scsp_pkg::USE_FAST_BIT];
      end
      ctrl_d.idle_periph_gate = bus.wdata[scsp_pkg::PERIPH_BIT];
      ctrl_d.sysclk_divider   = bus.wdata[scsp_pkg::DIV_LSB +: 2];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= '{default: 1'b0, sysclk_divider: scsp_pkg::DIV_RESET};
      // The trim starts from TRIM_INIT, so a build can choose its own nominal value.
      trim_q <= TRIM_INIT;
    end else if (ce_i) begin
      ctrl_q <= ctrl_d;
      if (bus.wr && hit_trim) begin
        trim_q <= bus.wdata[6:0];
      end
    end
  end

  assign ctrl_rd = {ctrl_q.slow_source_kind, ctrl_q.fast_source_kind, 1'b0,
                    ctrl_q.idle_periph_gate, ctrl_q.fast_osc_halt,
                    ctrl_q.sysclk_use_fast, ctrl_q.sysclk_divider};
  assign rd_mux  = hit_ctrl ? ctrl_rd :
                   hit_trim ? {1'b0, trim_q} : 8'h0000;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h0000;
    end else if (ce_i) begin
      rdata_o <= bus.rd ? rd_mux : 8'h0000;
    end
  end

  // The oscillators are asynchronous; an edge counts once stages two and three agree.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fast_sync_q <= 3'h0;
      slow_sync_q <= 3'h0;
      fast_lvl_q  <= 1'b0;
      slow_lvl_q  <= 1'b0;
    end else if (ce_i) begin
      fast_sync_q <= {fast_sync_q[1:0], fast_osc_i};
      slow_sync_q <= {slow_sync_q[1:0], slow_osc_i};
      if (fast_sync_q[1] == fast_sync_q[2]) begin
        fast_lvl_q <= fast_sync_q[2];
      end
      if (slow_sync_q[1] == slow_sync_q[2]) begin
        slow_lvl_q <= slow_sync_q[2];
      end
    end
  end

  assign fast_edge = (fast_sync_q[1] == fast_sync_q[2]) && fast_sync_q[2] && !fast_lvl_q;
  assign slow_edge = (slow_sync_q[1] == slow_sync_q[2]) && slow_sync_q[2] && !slow_lvl_q;

  // The source follows the register only at the end of a system period, so the period
  // in flight is never cut short. If the old source is dead, the switch waits for it.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_fast_q <= 1'b0;
    end else if (ce_i) begin
      if (tick) begin
        sel_fast_q <= ctrl_q.sysclk_use_fast;
      end
    end
  end

  assign src_edge = sel_fast_q ? fast_edge : slow_edge;

  scsp_tick_div u_div (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .src_edge_i (src_edge),
    .div_code_i (ctrl_q.sysclk_divider),
    .tick_o     (tick)
  );

  assign sys_tick_o           = tick;
  assign periph_tick_o        = tick && !(idle_mode_i && ctrl_q.idle_periph_gate);
  assign fast_osc_run_o       = !(ctrl_q.fast_osc_halt &&
                                  (!ctrl_q.sysclk_use_fast || idle_mode_i));
  assign fast_crystal_o       = ctrl_q.fast_source_kind;
  assign slow_crystal_o       = ctrl_q.slow_source_kind;
  assign xtal_pins_o          = ctrl_q.fast_source_kind || ctrl_q.slow_source_kind;
  assign xtal_high_gain_o     = ctrl_q.fast_source_kind;
  assign fast_rc_trim_value_o = trim_q;
  assign active_fast_o        = sel_fast_q;
endmodule : scsp_top
`default_nettype wire

//--- rtl/scsp_pkg.sv
// Constants, field layout and carrier types for the system clock select and prescale block.
// Assumes an 8-bit register port and a single 50 MHz core clock.
// What this block does
// - Bit7 picks slow source, only in fast mode.
// - Bit6 picks fast source, only in slow mode.
// - Bit4 gates peripheral clocks during Idle.
// - Bit3 halts fast clock in slow mode or Idle; changed only slow.
// - Bit2 picks system source while fast running.
// - Bits1-0 divide 16,4,2,1; reset value 11.
// - Seven-bit monotonic fast RC trim, read/write.
package scsp_pkg;
  localparam logic [7:0] CLOCK_SOURCE_CONTROL_ADDR = 8'h00d8;
  localparam logic [7:0] FAST_RC_TRIM_ADDR         = 8'h00f6;
  localparam int unsigned SLOW_KIND_BIT  = 7;
  localparam int unsigned FAST_KIND_BIT  = 6;
  localparam int unsigned PERIPH_BIT     = 4;
  localparam int unsigned HALT_BIT       = 3;
  localparam int unsigned USE_FAST_BIT   = 2;
  localparam int unsigned DIV_LSB        = 0;
  localparam logic [1:0] DIV_RESET       = 2'h3;
  localparam logic [6:0] TRIM_RESET      = 7'h40;
  localparam logic [1:0] DIV_BY_16       = 2'h0;
  localparam logic [1:0] DIV_BY_4        = 2'h1;
  localparam logic [1:0] DIV_BY_2        = 2'h2;
  localparam logic [1:0] DIV_BY_1        = 2'h3;
  localparam logic [3:0] TERM_16         = 4'h000f;
  localparam logic [3:0] TERM_4          = 4'h0003;
  localparam logic [3:0] TERM_2          = 4'h0001;
  localparam logic [3:0] TERM_1          = 4'h0000;

  typedef struct packed {
    logic       slow_source_kind;
    logic       fast_source_kind;
    logic       idle_periph_gate;
    logic       fast_osc_halt;
    logic       sysclk_use_fast;
    logic [1:0] sysclk_divider;
  } scsp_ctrl_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } scsp_bus_s;
endpackage : scsp_pkg

//--- rtl/scsp_tick_div.sv
// Divider that turns source edges into system clock ticks.
// Assumes src_edge_i is a one-cycle pulse per rising edge of the selected oscillator.
`timescale 1ns/10ps
`default_nettype none
module scsp_tick_div (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       src_edge_i,
  input  wire logic [1:0] div_code_i,
  output logic            tick_o
);
  logic [3:0] cnt_q;
  logic [3:0] term_q;
  logic [3:0] term_sel;
  logic       at_term;

  assign term_sel = (div_code_i == scsp_pkg::DIV_BY_16) ? scsp_pkg::TERM_16 :
                    (div_code_i == scsp_pkg::DIV_BY_4)  ? scsp_pkg::TERM_4  :
                    (div_code_i == scsp_pkg::DIV_BY_2)  ? scsp_pkg::TERM_2  :
                                                          scsp_pkg::TERM_1;
  assign at_term  = (cnt_q == term_q);

  // A new ratio is loaded only at a period boundary, so no short period is produced.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 4'h0000;
      term_q <= scsp_pkg::TERM_1;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= src_edge_i && at_term;
      if (src_edge_i) begin
        cnt_q <= at_term ? 4'h0000 : cnt_q + 4'h0001;
        if (at_term) begin
          term_q <= term_sel;
        end
      end
    end
  end
endmodule : scsp_tick_div
`default_nettype wire

//--- testbench/scsp_assertions.sv
// Checker for the clock select block, bound to scsp_top.
// Assumes one clock domain with an asynchronous active low reset.
`timescale 1ns/10ps
`default_nettype none
module scsp_assertions (
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       sys_tick_o,
  input wire logic       periph_tick_o,
  input wire logic       fast_crystal_o,
  input wire logic       slow_crystal_o,
  input wire logic       xtal_pins_o,
  input wire logic       xtal_high_gain_o,
  input wire logic [6:0] fast_rc_trim_value_o,
  input wire logic       active_fast_o
);
  localparam logic [7:0] CTL = scsp_pkg::CLOCK_SOURCE_CONTROL_ADDR;
  localparam logic [7:0] TRM = scsp_pkg::FAST_RC_TRIM_ADDR;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  AST_KIND_WRITE: assert property (
    $changed({slow_crystal_o, fast_crystal_o}) |-> $past(wr_i) && $past(addr_i) == CTL)
    else $error("kind moved");
  AST_KIND_READ: assert property (
    rd_i && addr_i == CTL |=> rdata_o[7:5] == {slow_crystal_o, fast_crystal_o, 1'b0})
    else $error("kind read");
  AST_PINS: assert property (
    xtal_pins_o == (slow_crystal_o | fast_crystal_o) && xtal_high_gain_o == fast_crystal_o)
    else $error("pins");
  AST_GATE: assert property (periph_tick_o |-> sys_tick_o)
    else $error("gate");
  AST_PULSE: assert property (sys_tick_o |=> !sys_tick_o)
    else $error("pulse");
  AST_TRIM_WRITE: assert property (
    $changed(fast_rc_trim_value_o) |-> $past(wr_i) && $past(addr_i) == TRM
    && {1'b0, fast_rc_trim_value_o} == ($past(wdata_i) & 8'h7f)) else $error("trim");
  AST_TRIM_READ: assert property (
    rd_i && addr_i == TRM |=> rdata_o == {1'b0, fast_rc_trim_value_o}) else $error("trim rd");
  AST_SWITCH: assert property (
    $changed(active_fast_o) |-> sys_tick_o || $past(sys_tick_o)) else $error("switch");
  cover property (sys_tick_o && active_fast_o);
  cover property (sys_tick_o && !periph_tick_o);
  cover property ($changed(active_fast_o));
endmodule : scsp_assertions
`default_nettype wire

//--- testbench/scsp_osc_model.sv
// Behavioural fast and slow oscillators.
// Assumes half periods are whole multiples of 20 ns, off the rising core clock edges.
`timescale 1ns/10ps
`default_nettype none
module scsp_osc_model #(
  parameter int FAST_HALF = 60,
  parameter int SLOW_HALF = 140
) (
  input  wire logic fast_run_i,
  output logic      fast_osc_o,
  output logic      slow_osc_o
);
  // A halted fast oscillator rests low, as a stopped clock would.
  initial begin
    fast_osc_o = 1'b0;
    slow_osc_o = 1'b0;
  end
  always #(SLOW_HALF) slow_osc_o = ~slow_osc_o;
  always #(FAST_HALF) fast_osc_o = fast_run_i & ~fast_osc_o;
endmodule : scsp_osc_model
`default_nettype wire

//--- testbench/testbench.sv
// Testbench: register tasks and tick period checks for scsp_top.
// Assumes the oscillator model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic       clock_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic       idle_mode_i = 1'b0, fast_osc_i, slow_osc_i, sys_tick_o, periph_tick_o;
  logic       fast_osc_run_o, fast_crystal_o, slow_crystal_o, xtal_pins_o, xtal_high_gain_o;
  logic       active_fast_o;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic [6:0] fast_rc_trim_value_o;
  logic [7:0] per [4] = '{8'he0, 8'h38, 8'h1c, 8'h0e};
  int         err_count = 0, comparisons = 0;
  scsp_top i_scsp_top (.*);
  scsp_osc_model i_scsp_osc_model (.fast_run_i(fast_osc_run_o), .fast_osc_o(fast_osc_i),
    .slow_osc_o(slow_osc_i));
  always #10 clock_i = ~clock_i;
  task automatic complete_run();
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk(rdata_o, exp);
    @(posedge clock_i);
  endtask : rd
  // Two ticks are skipped so a pending divider or source change has landed.
  task automatic gap(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (2) begin
      @(negedge clock_i);
      while (sys_tick_o !== 1'b1) @(negedge clock_i);
    end
    do begin
      @(negedge clock_i);
      n++;
    end while (sys_tick_o !== 1'b1);
    chk(n, exp);
    @(posedge clock_i);
  endtask : gap
  task automatic cnt(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (56) begin
      @(negedge clock_i);
      n += {7'h00, periph_tick_o};
    end
    chk(n, exp);
    @(posedge clock_i);
  endtask : cnt
  initial begin
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    rd(8'hd8, 8'h03);
    rd(8'hf6, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(8'hd8, 8'(i));
      gap(per[i]);
    end
    wr(8'hd8, 8'h13);
    idle_mode_i <= 1'b1;
    cnt(8'h00);
    wr(8'hd8, 8'h03);
    cnt(8'h04);
    idle_mode_i <= 1'b0;
    wr(8'hd8, 8'hc8);
    rd(8'hd8, 8'h48);
    chk({6'h00, xtal_pins_o, xtal_high_gain_o}, 8'h03);
    chk({7'h00, fast_osc_run_o}, 8'h00);
    wr(8'hd8, 8'h04);
    rd(8'hd8, 8'h00);
    chk({7'h00, fast_osc_run_o}, 8'h01);
    wr(8'hd8, 8'h27);
    rd(8'hd8, 8'h07);
    gap(8'h06);
    chk({7'h00, active_fast_o}, 8'h01);
    wr(8'hd8, 8'hcd);
    rd(8'hd8, 8'h85);
    chk({6'h00, xtal_pins_o, xtal_high_gain_o}, 8'h02);
    gap(8'h18);
    wr(8'hd8, 8'h03);
    gap(8'h0e);
    chk({7'h00, active_fast_o}, 8'h00);
    // A trim register write while the enable is low must leave the trim value untouched.
    ce_i <= 1'b0;
    wr(8'hf6, 8'h00);
    ce_i <= 1'b1;
    rd(8'hf6, 8'h40);
    wr(8'hf6, 8'hff);
    rd(8'hf6, 8'h7f);
    chk({1'b0, fast_rc_trim_value_o}, 8'h7f);
    wr(8'h55, 8'h00);
    rd(8'h55, 8'h00);
    rd(8'hf6, 8'h7f);
    // A reset in mid-run must bring back the reset values.
    rst_n_i <= 1'b0;
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    rd(8'hd8, 8'h03);
    rd(8'hf6, 8'h40);
    complete_run();
  end
  initial begin
    #400000;
    err_count++;
    complete_run();
  end
endmodule : testbench
bind scsp_top scsp_assertions i_scsp_assertions (.*);
`default_nettype wire
